// ==== rtl/static_mac_table.sv ====
`timescale 1ns/1ns
`default_nettype none
// Purpose: Static address table, VLAN table and indirect access path of the switch.
// Assumes: Byte register port driven by the serial manager; other tables sit behind ext_*.
// Notes: Triggers arriving while an external access is pending are dropped; see ind_busy.
module static_mac_table (
   input wire logic clk,               // Switch clock, 20 MHz
   input wire logic rst,               // Sync reset, high
   input wire logic ce,                // Clock enable, freezes all state when low
   input wire logic [7:0] reg_addr,    // Register offset
   input wire logic reg_wr,            // Register write strobe
   input wire logic reg_rd,            // Register read strobe
   input wire logic [7:0] reg_wdata,   // Register write data
   output logic [7:0] reg_rdata,       // Read data, valid the cycle after reg_rd
   output logic ind_busy,              // External indirect access pending
   output logic ext_req,               // Request to external table space
   output logic ext_wr,                // 1 write, 0 read
   output logic [2:0] ext_fsel,        // Function select of request
   output logic [1:0] ext_tsel,        // Table select of request
   output logic [11:0] ext_addr,       // Indirect address of request
   output logic [71:0] ext_wdata,      // Write data of request
   input wire logic [71:0] ext_rdata,  // Read data, valid with ext_ack
   input wire logic ext_ack,           // External access done
   input wire logic da_req,            // Destination lookup request
   input wire logic [47:0] da_mac,     // Destination address
   input wire logic [6:0] da_fid,      // Filter group id of frame
   input wire logic [2:0] ingress_port,// Ingress port 1 to 5
   input wire logic [4:0] stp_tx_en,   // Spanning-tree transmit enable per port
   input wire logic [4:0] stp_rx_en,   // Spanning-tree receive enable per port
   input wire logic dyn_hit,           // Dynamic table hit for da_req
   input wire logic [4:0] dyn_ports,   // Dynamic table forward mask
   input wire logic [4:0] flood_ports, // VLAN membership for a miss
   input wire logic sa_req,            // Source lookup request
   output logic sa_lookup_req,         // Source lookup passed to dynamic table
   output logic fwd_valid,             // Forward decision valid
   output logic [4:0] fwd_ports,       // Forward mask, bit 0 port 1
   output logic fwd_static             // Decision came from static table
);
   typedef struct packed {
      smt_pkg::ind_state_t state;
      logic [7:0] ctrl;
      logic [7:0] addr_lo;
      logic [71:0] data;
      logic [7:0] byte_a0;
      logic [7:0] rdata;
      logic ext_req;
      logic ext_wr;
      logic [2:0] ext_fsel;
      logic [1:0] ext_tsel;
      logic [11:0] ext_addr;
      logic [71:0] ext_wdata;
      logic fwd_valid;
      logic [4:0] fwd_ports;
      logic fwd_static;
   } regs_t;

   localparam regs_t REGS_RST = '{
      state: smt_pkg::st_idle,
      ctrl: smt_pkg::CTRL_RST,
      addr_lo: smt_pkg::ADDR_RST,
      data: smt_pkg::DATA_RST,
      byte_a0: 8'h00,
      rdata: 8'h00,
      ext_req: 1'h0,
      ext_wr: 1'h0,
      ext_fsel: 3'h0,
      ext_tsel: 2'h0,
      ext_addr: 12'h000,
      ext_wdata: 72'h0,
      fwd_valid: 1'h0,
      fwd_ports: 5'h00,
      fwd_static: 1'h0
   };

   regs_t r_r;
   regs_t r_nxt;
   logic [63:0] st_mem [smt_pkg::STATIC_ENTRIES];
   logic [51:0] vl_mem [smt_pkg::VLAN_SETS];
   logic st_we;
   logic vl_we;
   logic [63:0] st_wentry;
   logic [51:0] vl_rd_set;
   logic [63:0] vl_rd_wide;
   logic [51:0] vl_wr_set;
   logic trig;
   logic rd_dir;
   logic [2:0] fsel;
   logic [1:0] tsel;
   logic [9:0] idx10;
   logic [11:0] idx12;
   logic [4:0] in_mask;
   logic rx_ok;
   logic [4:0] st_fwd;

   lookup_if lk ();

   static_search u_search (
      .clk(clk),
      .rst(rst),
      .lk(lk)
   );

   assign lk.tbl = st_mem;
   assign lk.da = da_mac;
   assign lk.filter_group_id = da_fid;

   assign fsel = r_r.ctrl[smt_pkg::FSEL_MSB -: 3];
   assign tsel = r_r.ctrl[smt_pkg::TSEL_MSB -: 2];
   assign rd_dir = r_r.ctrl[smt_pkg::CTRL_RD_BIT];
   // Writing the low address register is the trigger; the high bits come from control
   assign trig = reg_wr && (reg_addr == smt_pkg::ADDR_OFS) && (r_r.state == smt_pkg::st_idle);
   assign idx10 = {r_r.ctrl[1:0], reg_wdata};
   assign idx12 = {r_r.ctrl[3:0], reg_wdata};

   // Write layout moves filter id and flag up one bit into the read layout
   assign st_wentry = {r_r.data[62:smt_pkg::WR_FID_LSB], r_r.data[smt_pkg::WR_USE_BIT], 1'h0,
      r_r.data[54:0]};

   assign vl_rd_set = vl_mem[idx10];
   for (genvar k = 0; k < smt_pkg::VLAN_PER_SET; k++) begin : g_vlan
      assign vl_rd_wide[smt_pkg::VLAN_STRIDE*k +: smt_pkg::VLAN_STRIDE] =
         {3'h0, vl_rd_set[smt_pkg::VLAN_ENTRY_W*k +: smt_pkg::VLAN_ENTRY_W]};
      assign vl_wr_set[smt_pkg::VLAN_ENTRY_W*k +: smt_pkg::VLAN_ENTRY_W] =
         r_r.data[smt_pkg::VLAN_STRIDE*k +: smt_pkg::VLAN_ENTRY_W];
   end

   assign in_mask = 5'(5'h01 << (ingress_port - 3'h1));
   assign rx_ok = |(stp_rx_en & in_mask);
   assign st_fwd = (lk.ports == smt_pkg::ALL_PORTS) ? (smt_pkg::ALL_PORTS & ~in_mask) : lk.ports;

   // Source lookups bypass this table entirely
   assign sa_lookup_req = sa_req;

   always_comb begin
      r_nxt = r_r;
      st_we = 1'h0;
      vl_we = 1'h0;
      if (reg_rd) begin
         r_nxt.rdata = 8'h00;
         if (reg_addr == smt_pkg::CTRL_OFS) begin
            r_nxt.rdata = r_r.ctrl;
         end else if (reg_addr == smt_pkg::ADDR_OFS) begin
            r_nxt.rdata = r_r.addr_lo;
         end else if (reg_addr == smt_pkg::BYTE_OFS) begin
            r_nxt.rdata = r_r.byte_a0;
         end else begin
            for (int i = 0; i < smt_pkg::DATA_BYTES; i++) begin
               if (reg_addr == smt_pkg::DATA_OFS + 8'(i)) begin
                  r_nxt.rdata = r_r.data[smt_pkg::DATA_W-1-8*i -: 8];
               end
            end
         end
      end
      if (reg_wr) begin
         if (reg_addr == smt_pkg::CTRL_OFS) begin
            r_nxt.ctrl = reg_wdata;
         end else if (reg_addr == smt_pkg::ADDR_OFS) begin
            r_nxt.addr_lo = reg_wdata;
         end else if (reg_addr == smt_pkg::BYTE_OFS) begin
            r_nxt.byte_a0 = reg_wdata;
         end else begin
            for (int i = 0; i < smt_pkg::DATA_BYTES; i++) begin
               if (reg_addr == smt_pkg::DATA_OFS + 8'(i)) begin
                  r_nxt.data[smt_pkg::DATA_W-1-8*i -: 8] = reg_wdata;
               end
            end
         end
      end
      // Table changes happen only here, from the manager's trigger
      if (trig) begin
         case (fsel)
            smt_pkg::FSEL_TABLE: begin
               case (tsel)
                  smt_pkg::TSEL_STATIC: begin
                     if (idx10 < 10'(smt_pkg::STATIC_ENTRIES)) begin
                        if (rd_dir) begin
                           r_nxt.data = {8'h00, st_mem[idx10[4:0]]};
                        end else begin
                           st_we = 1'h1;
                        end
                     end else if (rd_dir) begin
                        r_nxt.data = smt_pkg::DATA_RST;
                     end
                  end
                  smt_pkg::TSEL_VLAN: begin
                     if (rd_dir) begin
                        r_nxt.data = {8'h00, vl_rd_wide};
                     end else begin
                        vl_we = 1'h1;
                     end
                  end
                  default: begin
                     // Dynamic table and MIB counters live outside
                     r_nxt.state = smt_pkg::st_ext;
                     r_nxt.ext_req = 1'h1;
                     r_nxt.ext_wr = !rd_dir;
                     r_nxt.ext_fsel = fsel;
                     r_nxt.ext_tsel = tsel;
                     r_nxt.ext_addr = {2'h0, idx10};
                     r_nxt.ext_wdata = r_r.data;
                  end
               endcase
            end
            smt_pkg::FSEL_EEE, smt_pkg::FSEL_ACL, smt_pkg::FSEL_CFG: begin
               // Port number sits in the upper address nibble; data moves a byte at a time
               r_nxt.state = smt_pkg::st_ext;
               r_nxt.ext_req = 1'h1;
               r_nxt.ext_wr = !rd_dir;
               r_nxt.ext_fsel = fsel;
               r_nxt.ext_tsel = tsel;
               r_nxt.ext_addr = idx12;
               r_nxt.ext_wdata = {64'h0, r_r.byte_a0};
            end
            default: begin
               // Factory spaces: trigger has no effect
            end
         endcase
      end
      if (r_r.state == smt_pkg::st_ext && ext_ack) begin
         r_nxt.state = smt_pkg::st_idle;
         r_nxt.ext_req = 1'h0;
         if (!r_r.ext_wr) begin
            if (r_r.ext_fsel == smt_pkg::FSEL_TABLE) begin
               r_nxt.data = ext_rdata;
            end else begin
               r_nxt.byte_a0 = ext_rdata[7:0];
            end
         end
      end
      r_nxt.fwd_valid = da_req;
      if (da_req) begin
         if (lk.hit) begin
            r_nxt.fwd_static = 1'h1;
            if (lk.bypass) begin
               r_nxt.fwd_ports = st_fwd;
            end else begin
               r_nxt.fwd_ports = rx_ok ? (st_fwd & stp_tx_en) : 5'h00;
            end
         end else if (dyn_hit) begin
            r_nxt.fwd_static = 1'h0;
            r_nxt.fwd_ports = rx_ok ? (dyn_ports & stp_tx_en & ~in_mask) : 5'h00;
         end else begin
            r_nxt.fwd_static = 1'h0;
            r_nxt.fwd_ports = rx_ok ? (flood_ports & stp_tx_en & ~in_mask) : 5'h00;
         end
      end
   end

   // Static entries are cleared only by reset; no aging path exists
   always_ff @(posedge clk) begin
      if (rst) begin
         r_r <= REGS_RST;
         for (int i = 0; i < smt_pkg::STATIC_ENTRIES; i++) begin
            st_mem[i] <= 64'h0;
         end
      end else if (ce) begin
         r_r <= r_nxt;
         if (st_we) begin
            st_mem[idx10[4:0]] <= st_wentry;
         end
         if (vl_we) begin
            vl_mem[idx10] <= vl_wr_set;
         end
      end
   end

   assign reg_rdata = r_r.rdata;
   assign ind_busy = (r_r.state == smt_pkg::st_ext);
   assign ext_req = r_r.ext_req;
   assign ext_wr = r_r.ext_wr;
   assign ext_fsel = r_r.ext_fsel;
   assign ext_tsel = r_r.ext_tsel;
   assign ext_addr = r_r.ext_addr;
   assign ext_wdata = r_r.ext_wdata;
   assign fwd_valid = r_r.fwd_valid;
   assign fwd_ports = r_r.fwd_ports;
   assign fwd_static = r_r.fwd_static;

   logic wr_static_trig;
   logic rd_static_trig;
   logic data_touch;
   assign wr_static_trig = ce && trig && r_r.ctrl == 8'h00 && idx10 < 10'(smt_pkg::STATIC_ENTRIES);
   assign rd_static_trig = ce && trig && r_r.ctrl[7:2] == 6'h04;
   assign data_touch = reg_wr && (reg_addr >= smt_pkg::DATA_OFS) &&
      (reg_addr < smt_pkg::DATA_OFS + 8'(smt_pkg::DATA_BYTES));

   default clocking @(posedge clk); endclocking
   default disable iff (rst);

   a_static_write_fmt: assert property (wr_static_trig |=>
      st_mem[$past(idx10[4:0])] == {$past(r_r.data[62:55]), 1'h0, $past(r_r.data[54:0])})
      else $error("static write did not land in read layout");
   a_static_read_fmt: assert property (rd_static_trig |=>
      r_r.data[71:64] == 8'h00 && r_r.data[55] == 1'h0)
      else $error("static read returned reserved bits set");
   a_static_pref: assert property (ce && da_req && lk.hit && dyn_hit |=> fwd_valid && fwd_static)
      else $error("dynamic hit beat static hit");
   a_dyn_used: assert property (ce && da_req && !lk.hit && dyn_hit && rx_ok |=>
      !fwd_static && fwd_ports == $past(dyn_ports & stp_tx_en & ~in_mask))
      else $error("dynamic result not forwarded");
   a_ingress_excl: assert property (ce && da_req && (!lk.hit || lk.ports == 5'h1f) |=>
      (fwd_ports & $past(in_mask)) == 5'h00)
      else $error("frame sent back to ingress port");
   a_bypass_stp: assert property (ce && da_req && lk.hit && lk.bypass && lk.ports != 5'h1f |=>
      fwd_ports == $past(lk.ports))
      else $error("bypass entry blocked by spanning tree");
   a_no_aging: assert property (!(st_we && ce && idx10[4:0] == 5'h00) |=> $stable(st_mem[0]))
      else $error("static entry changed without a manager write");
   a_data_hold: assert property (ce && !trig && !data_touch && r_r.state == smt_pkg::st_idle |=>
      $stable(r_r.data))
      else $error("data bytes changed without an indirect operation");
   a_addr_high: assert property (ce && trig && fsel == 3'h0 && tsel[1] |=>
      ext_req && ext_addr[9:8] == $past(r_r.ctrl[1:0]) && ext_addr[7:0] == $past(reg_wdata))
      else $error("indirect address bits misplaced");
   a_reserved_fsel: assert property (ce && trig && (fsel == 3'h3 || fsel == 3'h5 || fsel[2:1] == 2'h3) |=>
      !ext_req)
      else $error("factory space started an access");
   a_fwd_pulse: assert property (ce |=> fwd_valid == $past(da_req))
      else $error("forward decision not one cycle after request");
   a_flood_miss: assert property (ce && da_req && !lk.hit && !dyn_hit && rx_ok |=>
      !fwd_static && fwd_ports == $past(flood_ports & stp_tx_en & ~in_mask))
      else $error("missed lookup not flooded to members");
   a_rx_block: assert property (ce && da_req && !rx_ok && !(lk.hit && lk.bypass) |=>
      fwd_ports == 5'h00)
      else $error("frame forwarded from a receive-disabled port");
   a_static_ports: assert property (ce && da_req && lk.hit && !lk.bypass && rx_ok && lk.ports != 5'h1f |=>
      fwd_static && fwd_ports == $past(lk.ports & stp_tx_en))
      else $error("static port mask not applied");
   // The far side may take many cycles, so the request must not wander while it waits
   a_ext_steady: assert property (ce && ext_req && !ext_ack |=> ext_req && $stable(ext_addr) &&
      $stable(ext_wdata) && $stable(ext_wr))
      else $error("external request changed before its answer");
   // Entry 0 alone says little; every entry may change only through a manager write
   for (genvar j = 0; j < smt_pkg::STATIC_ENTRIES; j++) begin : g_keep
      a_entry_kept: assert property (!(ce && st_we && idx10[4:0] == 5'(j)) |=> $stable(st_mem[j]))
         else $error("static entry changed without a manager write");
   end

   c_static_read: cover property (rd_static_trig ##1 reg_rd);
   c_static_write: cover property (wr_static_trig);
   c_both_hit: cover property (ce && da_req && lk.hit && dyn_hit);
   c_ext_done: cover property (ext_req ##[1:20] ext_ack);
   c_vlan_read: cover property (ce && trig && fsel == 3'h0 && tsel == smt_pkg::TSEL_VLAN && rd_dir);
endmodule
`default_nettype wire

// ==== rtl/smt_pkg.sv ====
// Purpose: Constants and types for the static address table and indirect access block.
// Assumes: Byte-wide register port, one switch clock.
// Notes: Register offsets, control fields, table sizes and layout bit positions follow.
package smt_pkg;
   localparam logic [7:0] CTRL_OFS = 8'h6e;
   localparam logic [7:0] ADDR_OFS = 8'h6f;
   localparam logic [7:0] DATA_OFS = 8'h70;
   localparam logic [7:0] BYTE_OFS = 8'ha0;
   localparam int DATA_BYTES = 9;
   localparam int DATA_W = 72;
   localparam int CTRL_RD_BIT = 4;
   localparam int FSEL_MSB = 7;
   localparam int TSEL_MSB = 3;
   localparam logic [2:0] FSEL_TABLE = 3'h0;
   localparam logic [2:0] FSEL_EEE = 3'h1;
   localparam logic [2:0] FSEL_ACL = 3'h2;
   localparam logic [2:0] FSEL_CFG = 3'h4;
   localparam logic [1:0] TSEL_STATIC = 2'h0;
   localparam logic [1:0] TSEL_VLAN = 2'h1;
   localparam logic [1:0] TSEL_DYN = 2'h2;
   localparam logic [1:0] TSEL_MIB = 2'h3;
   localparam int STATIC_ENTRIES = 32;
   localparam int VLAN_SETS = 1024;
   localparam int VLAN_ENTRY_W = 13;
   localparam int VLAN_STRIDE = 16;
   localparam int VLAN_PER_SET = 4;
   localparam int RD_FID_LSB = 57;
   localparam int RD_USE_BIT = 56;
   localparam int BYPASS_BIT = 54;
   localparam int VALID_BIT = 53;
   localparam int PORTS_LSB = 48;
   localparam int WR_FID_LSB = 56;
   localparam int WR_USE_BIT = 55;
   localparam int FID_W = 7;
   localparam int PORT_N = 5;
   localparam logic [4:0] ALL_PORTS = 5'h1f;
   localparam logic [7:0] CTRL_RST = 8'h00;
   localparam logic [7:0] ADDR_RST = 8'h00;
   localparam logic [71:0] DATA_RST = 72'h0;
   typedef enum logic {st_idle = 1'b0, st_ext = 1'b1} ind_state_t;
endpackage

// ==== rtl/lookup_if.sv ====
`timescale 1ns/1ns
`default_nettype none
// Purpose: Carries the static table and one destination search between table and matcher.
// Assumes: Table is held in the read layout.
// Notes: The matcher is purely combinational.
interface lookup_if;
   logic [63:0] tbl [smt_pkg::STATIC_ENTRIES];
   logic [47:0] da;
   logic [6:0] filter_group_id;
   logic hit;
   logic [4:0] idx;
   logic [4:0] ports;
   logic bypass;
   modport table_side (output tbl, da, filter_group_id, input hit, idx, ports, bypass);
   modport search_side (input tbl, da, filter_group_id, output hit, idx, ports, bypass);
endinterface
`default_nettype wire

// ==== rtl/static_search.sv ====
`timescale 1ns/1ns
`default_nettype none
// Purpose: Searches all static entries for a destination address.
// Assumes: Entries in read layout.
// Notes: Lowest matching index wins when the manager loads duplicates.
module static_search (
   input wire logic clk,               // Switch clock, assertions only
   input wire logic rst,               // Sync reset, assertions only
   lookup_if.search_side lk            // Table and search
);
   logic [smt_pkg::STATIC_ENTRIES-1:0] match;

   for (genvar i = 0; i < smt_pkg::STATIC_ENTRIES; i++) begin : g_ent
      logic [63:0] e;
      assign e = lk.tbl[i];
      assign match[i] = e[smt_pkg::VALID_BIT] && (e[47:0] == lk.da) &&
         (!e[smt_pkg::RD_USE_BIT] || (e[63:smt_pkg::RD_FID_LSB] == lk.filter_group_id));
   end

   always_comb begin
      lk.hit = 1'h0;
      lk.idx = 5'h00;
      for (int i = smt_pkg::STATIC_ENTRIES - 1; i >= 0; i--) begin
         if (match[i]) begin
            lk.hit = 1'h1;
            lk.idx = 5'(i);
         end
      end
   end

   assign lk.ports = lk.tbl[lk.idx][52:smt_pkg::PORTS_LSB];
   assign lk.bypass = lk.tbl[lk.idx][smt_pkg::BYPASS_BIT];

   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   a_hit_needs_valid: assert property (lk.hit |-> lk.tbl[lk.idx][smt_pkg::VALID_BIT])
      else $error("static hit on an invalid entry");
   a_match_fid_rule: assert property (lk.hit |-> lk.tbl[lk.idx][47:0] == lk.da &&
      (!lk.tbl[lk.idx][smt_pkg::RD_USE_BIT] || lk.tbl[lk.idx][63:smt_pkg::RD_FID_LSB] == lk.filter_group_id))
      else $error("static hit without address or filter id match");
endmodule
`default_nettype wire

// ==== tb/ext_table_model.sv ====
// Purpose: Far-side table space that answers indirect requests.
// Assumes: One request outstanding; ext_req drops after the answer is taken.
// Notes: Read data is six copies of the request address, garbage between answers.
`timescale 1ns/1ns
`default_nettype none
module ext_table_model (
   input wire logic clk, // Switch clock
   input wire logic ext_req, // Request level
   input wire logic [11:0] ext_addr, // Request address
   input wire logic [3:0] lat, // Cycles before the answer
   output logic ext_ack, // Answer pulse
   output logic [71:0] ext_rdata // Read data, valid with ext_ack
);
   logic [3:0] cnt = 4'h0;
   logic [7:0] tick = 8'h00;
   initial ext_ack = 1'b0;
   initial ext_rdata = 72'h0;
   always @(posedge clk) begin
      tick <= tick + 8'h01;
      ext_ack <= 1'b0;
      // Changes every cycle so stale data never looks valid
      ext_rdata <= {9{~tick}};
      if (!ext_req) begin
         cnt <= 4'h0;
      end else if (!ext_ack && cnt != 4'hf) begin
         cnt <= cnt + 4'h1;
         if (cnt == lat) begin
            ext_ack <= 1'b1;
            ext_rdata <= {6{ext_addr}};
            cnt <= 4'hf;
         end
      end
   end
endmodule
`default_nettype wire

// ==== tb/tb_top.sv ====
// Purpose: Self-checking bench of the static table, lookup and indirect path.
// Assumes: Table space model answers after a random latency.
// Notes: Strobes stay high between back-to-back register operations.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
   logic clk, rst, ce, reg_wr, reg_rd, ind_busy, ext_req, ext_wr, ext_ack, da_req, dyn_hit, sa_req;
   logic sa_lookup_req, fwd_valid, fwd_static;
   logic [7:0] reg_addr, reg_wdata, reg_rdata;
   logic [2:0] ext_fsel, ingress_port;
   logic [1:0] ext_tsel;
   logic [11:0] ext_addr;
   logic [71:0] ext_wdata, ext_rdata, ev;
   logic [47:0] da_mac;
   logic [6:0] da_fid, f;
   logic [4:0] stp_tx_en, stp_rx_en, dyn_ports, flood_ports, fwd_ports;
   logic [3:0] lat;
   logic [47:0] m [4];
   logic [31:0] r;
   logic [7:0] cc [6] = '{8'h1b, 8'h1d, 8'h32, 8'h54, 8'h90, 8'h94};
   logic [7:0] aa [6] = '{8'hff, 8'h00, 8'h05, 8'h1f, 8'h03, 8'h12};
   int failures = 0;
   int compares = 0;
   static_mac_table i_dut (.clk, .rst, .ce, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .ind_busy,
      .ext_req, .ext_wr, .ext_fsel, .ext_tsel, .ext_addr, .ext_wdata, .ext_rdata, .ext_ack, .da_req, .da_mac,
      .da_fid, .ingress_port, .stp_tx_en, .stp_rx_en, .dyn_hit, .dyn_ports, .flood_ports, .sa_req,
      .sa_lookup_req, .fwd_valid, .fwd_ports, .fwd_static);
   ext_table_model i_mdl (.clk, .ext_req, .ext_addr, .lat, .ext_ack, .ext_rdata);
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   task finish_test;
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task chk(input logic [71:0] got, exp);
      compares++;
      if (got !== exp) begin
         failures++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   function logic [11:0] ea_of(input logic [7:0] c, a);
      return (c[7:5] == 3'h0) ? {2'h0, c[1:0], a} : {c[3:0], a};
   endfunction
   function logic [71:0] vl_of(input logic [63:0] v);
      logic [71:0] e;
      e = 72'h0;
      for (int k = 0; k < 4; k++) e[16 * k +: 13] = v[16 * k +: 13];
      return e;
   endfunction
   task wr(input logic [7:0] a, d);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      reg_rd = 1'b0;
      @(negedge clk);
   endtask
   task rd(input logic [7:0] a, input logic [71:0] e);
      reg_addr = a;
      reg_rd = 1'b1;
      reg_wr = 1'b0;
      @(negedge clk);
      chk(reg_rdata, e);
   endtask
   task idle;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      da_req = 1'b0;
      sa_req = 1'b0;
      @(negedge clk);
   endtask
   task sr(input logic [4:0] i, input logic [63:0] e);
      logic [71:0] x;
      x = {8'h00, e};
      wr(8'h6e, 8'h10);
      wr(8'h6f, {3'h0, i});
      for (int k = 0; k < 9; k++) rd(8'(8'h70 + k), x[71 - 8 * k -: 8]);
      idle;
   endtask
   task ent(input logic [4:0] i, input logic [6:0] fd, input logic fl, bp, vl, input logic [4:0] pm,
      input logic [47:0] mc);
      logic [63:0] w;
      w = {1'b0, fd, fl, bp, vl, pm, mc};
      for (int k = 0; k < 8; k++) wr(8'(8'h71 + k), w[63 - 8 * k -: 8]);
      wr(8'h6e, 8'h00);
      wr(8'h6f, {3'h0, i});
      idle;
      sr(i, {fd, fl, 1'b0, bp, vl, pm, mc});
   endtask
   task look(input logic [47:0] mc, input logic [6:0] fd, input logic [2:0] ig, input logic [4:0] tx, rx,
      input logic dh, input logic [4:0] dp, fp, ep, input logic es);
      da_req = 1'b1;
      da_mac = mc;
      da_fid = fd;
      ingress_port = ig;
      stp_tx_en = tx;
      stp_rx_en = rx;
      dyn_hit = dh;
      dyn_ports = dp;
      flood_ports = fp;
      @(negedge clk);
      chk(fwd_valid, 1'b1);
      chk(fwd_ports, ep);
      chk(fwd_static, es);
   endtask
   task ex(input logic [7:0] c, a, input logic [71:0] ew);
      int n;
      lat = 4'($urandom_range(0, 9));
      wr(8'h6e, c);
      wr(8'h6f, a);
      idle;
      chk(ext_req, 1'b1);
      chk(ind_busy, 1'b1);
      chk(ext_addr, ea_of(c, a));
      chk(ext_fsel, c[7:5]);
      chk(ext_wr, !c[4]);
      if (c[7:5] == 3'h0) chk(ext_tsel, c[3:2]);
      if (!c[4]) chk(ext_wdata, ew);
      n = 0;
      while (ind_busy === 1'b1 && n < 40) begin
         @(negedge clk);
         n++;
      end
      chk(ind_busy, 1'b0);
   endtask
   initial begin
      #500000;
      failures++;
      $display("watchdog expired");
      finish_test;
   end
   initial begin
      rst = 1'b1;
      ce = 1'b1;
      {reg_addr, reg_wdata, reg_wr, reg_rd, da_req, sa_req, da_mac, da_fid, ingress_port} = '0;
      {stp_tx_en, stp_rx_en, dyn_hit, dyn_ports, flood_ports} = '0;
      lat = 4'h3;
      void'($urandom(32'h1d70));
      for (int k = 0; k < 4; k++) m[k] = 48'({$urandom, $urandom});
      f = 7'($urandom);
      repeat (20) @(negedge clk);
      rst = 1'b0;
      @(negedge clk);
      rd(8'h6e, 8'h00);
      rd(8'h55, 8'h00);
      sr(5'd3, 64'h0);
      $display("test reset done");
      ent(5'd3, 7'h00, 1'b0, 1'b0, 1'b1, 5'h06, m[0]);
      ent(5'd4, 7'h00, 1'b0, 1'b1, 1'b1, 5'h1f, m[1]);
      ent(5'd5, 7'h00, 1'b0, 1'b0, 1'b0, 5'h09, m[2]);
      ent(5'd6, f, 1'b1, 1'b0, 1'b1, 5'h11, m[3]);
      r = $urandom;
      ent(5'd31, r[6:0], r[7], r[8], r[9], r[14:10], 48'({$urandom, $urandom}));
      $display("test table access done");
      look(m[0], 7'h00, 3'd1, 5'h1f, 5'h1f, 1'b1, 5'h18, 5'h1f, 5'h06, 1'b1);
      look(m[0], 7'h55, 3'd2, 5'h1f, 5'h1f, 1'b0, 5'h00, 5'h00, 5'h06, 1'b1);
      look(m[0], 7'h00, 3'd1, 5'h1f, 5'h1e, 1'b1, 5'h18, 5'h1f, 5'h00, 1'b1);
      look(m[1], 7'h00, 3'd1, 5'h00, 5'h1e, 1'b0, 5'h00, 5'h00, 5'h1e, 1'b1);
      look(m[2], 7'h00, 3'd2, 5'h1f, 5'h1f, 1'b0, 5'h00, 5'h1f, 5'h1d, 1'b0);
      look(m[3], f ^ 7'h01, 3'd3, 5'h1f, 5'h1f, 1'b1, 5'h0f, 5'h1f, 5'h0b, 1'b0);
      look(m[3], f, 3'd3, 5'h1f, 5'h1f, 1'b1, 5'h0f, 5'h1f, 5'h11, 1'b1);
      idle;
      sa_req = 1'b1;
      #1;
      chk(sa_lookup_req, 1'b1);
      @(negedge clk);
      chk(fwd_valid, 1'b0);
      idle;
      $display("test lookup done");
      for (int k = 0; k < 6; k++) begin
         ex(cc[k], aa[k], 72'h0);
         ev = {6{ea_of(cc[k], aa[k])}};
         if (cc[k][7:5] == 3'h0) begin
            for (int j = 0; j < 9; j++) rd(8'(8'h70 + j), ev[71 - 8 * j -: 8]);
            idle;
            idle;
            rd(8'h70, ev[71:64]);
         end else begin
            rd(8'ha0, ev[7:0]);
         end
         idle;
      end
      r = $urandom;
      wr(8'ha0, r[7:0]);
      ex(8'h23, 8'h01, {64'h0, r[7:0]});
      wr(8'h6e, 8'hd0);
      wr(8'h6f, 8'h00);
      idle;
      chk(ind_busy, 1'b0);
      chk(ext_req, 1'b0);
      ce = 1'b0;
      wr(8'h6e, 8'h55);
      idle;
      ce = 1'b1;
      rd(8'h6e, 8'hd0);
      $display("test indirect done");
      r = $urandom;
      ev = {8'h00, $urandom, r};
      for (int k = 0; k < 8; k++) wr(8'(8'h71 + k), ev[63 - 8 * k -: 8]);
      wr(8'h6e, 8'h06);
      wr(8'h6f, 8'h35);
      wr(8'h6e, 8'h16);
      wr(8'h6f, 8'h35);
      idle;
      ev = vl_of(ev[63:0]);
      for (int k = 0; k < 9; k++) rd(8'(8'h70 + k), ev[71 - 8 * k -: 8]);
      idle;
      $display("test vlan done");
      sr(5'd3, {7'h00, 1'b0, 1'b0, 1'b0, 1'b1, 5'h06, m[0]});
      $display("test persistence done");
      finish_test;
   end
endmodule
`default_nettype wire
